// File: rtl/mtc_top.sv
// Multimode 16-bit timer counter with Avalon-MM register slave
`timescale 1ns/10ps
`default_nettype none
`include "mtc_map.svh"
module mtc_top (
  input  wire logic                mclk,
  input  wire logic                nrst,
  input  wire logic                timer_input_pin,
  input  wire logic                slow_mode,
  input  wire logic                slow_clk_tick,
  input  wire logic                stop_entry,
  input  wire mtc_pkg::mtc_avreq_t avs_req,
  output logic [31:0]              avs_readdata,
  output logic                     avs_waitrequest,
  output logic                     match_interrupt
);
  import mtc_pkg::*;

  mtc_ctrl_t  ctrl_r;
  mtc_ctrl_t  ctrl_nxt;
  mtc_state_t state_r;
  logic [15:0] cnt_r;
  logic [15:0] limit_r;
  logic [15:0] stage_r;
  logic [15:0] cap_r;
  logic        commit_r;
  logic [10:0] div_r;
  logic [2:0]  fsdiv_r;
  logic        pin_lvl;
  logic        lvl_d_r;
  logic        pin_rise;
  logic        pin_fall;
  logic        fs_tick;
  logic        src_tick;
  logic        is_free;
  logic        is_trig;
  logic        is_event;
  logic        is_window;
  logic        trig_edge;
  logic        opp_edge;
  logic        gate;
  logic        cnt_ev;
  logic        commit_ev;
  logic        bus_req;
  logic        bus_take;
  logic        wr_ctrl;
  logic        wr_limit;

  function automatic logic tap_hit(input logic [10:0] div, input logic [10:0] mask);
    tap_hit = (div & mask) == mask;
  endfunction : tap_hit

  function automatic logic next_hits(input logic [15:0] cnt, input logic [15:0] lim);
    next_hits = (cnt + 16'h0001) == lim;
  endfunction : next_hits

  mtc_filter u_filter (
    .mclk   (mclk),
    .nrst   (nrst),
    .pin    (timer_input_pin),
    .bypass (slow_mode),
    .lvl_r  (pin_lvl)
  );

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      lvl_d_r <= 1'b0;
    end else begin
      lvl_d_r <= pin_lvl;
    end
  end

  assign pin_rise = pin_lvl & ~lvl_d_r;
  assign pin_fall = ~pin_lvl & lvl_d_r;

  // Free-running divider; taps give the three fast resolutions
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      div_r <= 11'h000;
    end else begin
      div_r <= div_r + 11'h001;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      fsdiv_r <= 3'h0;
    end else if (slow_clk_tick) begin
      fsdiv_r <= fsdiv_r + 3'h1;
    end
  end

  assign fs_tick = slow_clk_tick && (fsdiv_r == `MTC_FS_DIV_LAST);

  // Only the slowest code survives slow mode; the fast taps give no ticks there
  always_comb begin
    case (ctrl_r.source_clock_select)
      2'h0: src_tick = (slow_mode || ctrl_r.divider_tap_select) ? fs_tick : tap_hit(div_r, `MTC_TAP_SLOW);
      2'h1: src_tick = !slow_mode && tap_hit(div_r, `MTC_TAP_MID);
      2'h2: src_tick = !slow_mode && tap_hit(div_r, `MTC_TAP_FAST);
      default: src_tick = 1'b0;
    endcase
  end

  always_comb begin
    is_event  = ctrl_r.operating_mode_select == `MTC_MODE_TIMER &&
                ctrl_r.source_clock_select == `MTC_CK_EXT && ctrl_r.start_edge_select[1];
    is_trig   = ctrl_r.operating_mode_select == `MTC_MODE_TIMER &&
                ctrl_r.source_clock_select != `MTC_CK_EXT && ctrl_r.start_edge_select[1];
    is_free   = ctrl_r.operating_mode_select == `MTC_MODE_TIMER &&
                ctrl_r.source_clock_select != `MTC_CK_EXT &&
                ctrl_r.start_edge_select == `MTC_START_CMD;
    is_window = ctrl_r.operating_mode_select == `MTC_MODE_WINDOW &&
                ctrl_r.source_clock_select != `MTC_CK_EXT && ctrl_r.start_edge_select[1];
    trig_edge = ctrl_r.start_edge_select[0] ? pin_fall : pin_rise;
    opp_edge  = ctrl_r.start_edge_select[0] ? pin_rise : pin_fall;
    gate      = ctrl_r.start_edge_select[0] ? ~pin_lvl : pin_lvl;
    cnt_ev    = is_event ? trig_edge : (is_window ? (src_tick && gate) : (is_free && src_tick));
    commit_ev = is_event ? trig_edge : src_tick;
  end

  // Counter core: trigger and event modes have their own branch, free and window share the counting branch
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      cnt_r           <= 16'h0000;
      state_r         <= MTC_WAIT;
      match_interrupt <= 1'b0;
    end else begin
      match_interrupt <= 1'b0;
      if (is_trig) begin
        case (state_r)
          MTC_WAIT: begin
            // A halted timer sits at zero, whatever the previous mode left behind
            cnt_r <= 16'h0000;
            if (trig_edge) begin
              state_r <= MTC_RUN;
            end
          end
          MTC_RUN: begin
            if (src_tick && next_hits(cnt_r, limit_r)) begin
              cnt_r           <= 16'h0000;
              state_r         <= MTC_WAIT;
              match_interrupt <= 1'b1;
            end else if (ctrl_r.trigger_stop_select && opp_edge) begin
              cnt_r   <= 16'h0000;
              state_r <= MTC_WAIT;
            end else if (src_tick) begin
              cnt_r <= cnt_r + 16'h0001;
            end
          end
          default: begin
            state_r <= MTC_WAIT;
          end
        endcase
      end else if (is_event) begin
        state_r <= MTC_WAIT;
        if (trig_edge) begin
          cnt_r <= cnt_r + 16'h0001;
        end else if (opp_edge && cnt_r == limit_r) begin
          cnt_r           <= 16'h0000;
          match_interrupt <= 1'b1;
        end
      end else if (cnt_ev) begin
        state_r <= MTC_WAIT;
        if (next_hits(cnt_r, limit_r)) begin
          cnt_r           <= 16'h0000;
          match_interrupt <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 16'h0001;
        end
      end else begin
        state_r <= MTC_WAIT;
        if (!(is_free || is_window)) begin
          cnt_r <= 16'h0000;
        end
      end
    end
  end

  // Capture follows the counter on every free, window and event-mode counting event while enabled
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      cap_r <= 16'h0000;
    end else if (ctrl_r.autocapture_enable && cnt_ev) begin
      cap_r <= cnt_r;
    end
  end

  // Register slave: one wait cycle, then the answer
  assign bus_req  = avs_req.read || avs_req.write;
  assign bus_take = bus_req && !avs_waitrequest;
  assign wr_ctrl  = bus_take && avs_req.write && avs_req.address == `MTC_OFS_CTRL;
  assign wr_limit = bus_take && avs_req.write && avs_req.address == `MTC_OFS_LIMIT;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !(bus_req && avs_waitrequest);
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (bus_req && avs_waitrequest && avs_req.read) begin
      case (avs_req.address)
        `MTC_OFS_CTRL:    avs_readdata <= {23'h0, ctrl_r};
        `MTC_OFS_LIMIT:   avs_readdata <= {16'h0000, limit_r};
        `MTC_OFS_CAPTURE: avs_readdata <= {16'h0000, cap_r};
        `MTC_OFS_STATUS:  avs_readdata <= {14'h0, commit_r, state_r == MTC_RUN, cnt_r};
        default:          avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl && avs_req.byteenable[0]) begin
      ctrl_nxt[7:0] = avs_req.writedata[7:0];
    end
    if (wr_ctrl && avs_req.byteenable[1]) begin
      ctrl_nxt[8] = avs_req.writedata[8];
    end
    if (stop_entry) begin
      ctrl_nxt.start_edge_select = `MTC_START_STOP;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ctrl_r <= `MTC_CTRL_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // Staged limit; a high-byte write arms the load, a new arm beats a pending load
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      stage_r  <= `MTC_LIMIT_RST;
      limit_r  <= `MTC_LIMIT_RST;
      commit_r <= 1'b0;
    end else begin
      if (commit_r && commit_ev) begin
        limit_r  <= stage_r;
        commit_r <= 1'b0;
      end
      if (wr_limit && avs_req.byteenable[0]) begin
        stage_r[7:0] <= avs_req.writedata[7:0];
      end
      if (wr_limit && avs_req.byteenable[1]) begin
        stage_r[15:8] <= avs_req.writedata[15:8];
        commit_r      <= 1'b1;
      end
    end
  end

  property p_free_match;
    @(posedge mclk) disable iff (!nrst)
      (is_free && src_tick && next_hits(cnt_r, limit_r)) |=> (cnt_r == 16'h0000 && match_interrupt);
  endproperty
  a_free_match: assert property (p_free_match) else $error("free timer missed match clear");

  property p_irq_pulse;
    @(posedge mclk) disable iff (!nrst)
      match_interrupt |=> !match_interrupt;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt longer than one cycle");

  property p_capture;
    @(posedge mclk) disable iff (!nrst)
      (ctrl_r.autocapture_enable && cnt_ev) |=> cap_r == $past(cnt_r);
  endproperty
  a_capture: assert property (p_capture) else $error("capture did not follow counter");

  property p_trig_abort;
    @(posedge mclk) disable iff (!nrst)
      (is_trig && state_r == MTC_RUN && ctrl_r.trigger_stop_select && opp_edge &&
       !(src_tick && next_hits(cnt_r, limit_r)))
      |=> (cnt_r == 16'h0000 && state_r == MTC_WAIT && !match_interrupt);
  endproperty
  a_trig_abort: assert property (p_trig_abort) else $error("opposite edge did not halt quietly");

  property p_trig_ignore;
    @(posedge mclk) disable iff (!nrst)
      (is_trig && state_r == MTC_RUN && !ctrl_r.trigger_stop_select && !src_tick && !stop_entry && !wr_ctrl)
      |=> (cnt_r == $past(cnt_r) && state_r == MTC_RUN);
  endproperty
  a_trig_ignore: assert property (p_trig_ignore) else $error("edge disturbed running trigger timer");

  property p_trig_start;
    @(posedge mclk) disable iff (!nrst)
      (is_trig && state_r == MTC_WAIT && trig_edge) |=> state_r == MTC_RUN;
  endproperty
  a_trig_start: assert property (p_trig_start) else $error("trigger edge did not start counter");

  property p_event_count;
    @(posedge mclk) disable iff (!nrst)
      (is_event && trig_edge) |=> (cnt_r == $past(cnt_r) + 16'h0001 && !match_interrupt);
  endproperty
  a_event_count: assert property (p_event_count) else $error("event edge not counted");

  property p_event_match;
    @(posedge mclk) disable iff (!nrst)
      (is_event && opp_edge && cnt_r == limit_r) |=> (cnt_r == 16'h0000 && match_interrupt);
  endproperty
  a_event_match: assert property (p_event_match) else $error("event match not at opposite edge");

  property p_limit_hold;
    @(posedge mclk) disable iff (!nrst)
      !(commit_r && commit_ev) |=> limit_r == $past(limit_r);
  endproperty
  a_limit_hold: assert property (p_limit_hold) else $error("limit changed without armed load");

  property p_stop_entry;
    @(posedge mclk) disable iff (!nrst)
      stop_entry |=> ctrl_r.start_edge_select == `MTC_START_STOP ##1 cnt_r == 16'h0000;
  endproperty
  a_stop_entry: assert property (p_stop_entry) else $error("stop entry did not halt counter");

  property p_window_gate;
    @(posedge mclk) disable iff (!nrst)
      (is_window && !gate) |=> cnt_r == $past(cnt_r);
  endproperty
  a_window_gate: assert property (p_window_gate) else $error("window counted outside gate");
endmodule : mtc_top
`default_nettype wire

// File: rtl/mtc_map.svh
// Register map, field reset values and timing constants for the multimode timer counter
// Summary of operation
// - Free timer counts source ticks, clears on match
// - Auto-capture copies counter on each counting event, none in triggered timer
// - Codes 00/01/10 select divider taps; slow uses 00
// - Trigger edge on pin starts triggered timer
// - Stop-select 1: opposite edge halts without interrupt
// - Halted triggered timer restarts on next trigger
// - Stop-select 0: opposite and early triggers ignored
// - Filter drops short pulses; hold 5 periods
// - Filter bypassed in slow mode; hold one cycle
// - Event mode counts selected pin edges, clears on match
// - Event match checked at the opposite edge
// - Window mode counts ticks gated by pin level
// - Limit loads at source tick (event mode: trigger edge) after upper byte
// - Stop power entry forces start field to stop
`ifndef MTC_MAP_SVH
`define MTC_MAP_SVH
`define MTC_OFS_CTRL      4'h0
`define MTC_OFS_LIMIT     4'h4
`define MTC_OFS_CAPTURE   4'h8
`define MTC_OFS_STATUS    4'hc
`define MTC_CTRL_RST      9'h000
`define MTC_LIMIT_RST     16'hffff
`define MTC_ST_RUN_BIT    16
`define MTC_ST_PEND_BIT   17
`define MTC_TAP_SLOW      11'h7ff
`define MTC_TAP_MID       11'h07f
`define MTC_TAP_FAST      11'h007
`define MTC_FS_DIV_LAST   3'h7
`define MTC_FILT_REJECT_FC 4
`define MTC_FILT_ACCEPT_CYC (3'(`MTC_FILT_REJECT_FC + 1))
`define MTC_MODE_TIMER    2'h0
`define MTC_MODE_WINDOW   2'h1
`define MTC_START_STOP    2'h0
`define MTC_START_CMD     2'h1
`define MTC_CK_EXT        2'h3
`endif

// File: rtl/mtc_pkg.sv
// Types shared by the multimode timer counter
package mtc_pkg;
  typedef struct packed {
    logic       divider_tap_select;
    logic       trigger_stop_select;
    logic       autocapture_enable;
    logic [1:0] start_edge_select;
    logic [1:0] operating_mode_select;
    logic [1:0] source_clock_select;
  } mtc_ctrl_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } mtc_avreq_t;

  typedef enum logic {
    MTC_WAIT,
    MTC_RUN
  } mtc_state_t;
endpackage : mtc_pkg

// File: rtl/mtc_filter.sv
// Input pin synchroniser and noise filter
`timescale 1ns/10ps
`default_nettype none
`include "mtc_map.svh"
module mtc_filter (
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic pin,
  input  wire logic bypass,
  output logic      lvl_r
);
  logic       s1_r;
  logic       s2_r;
  logic       s3_r;
  logic [2:0] run_r;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Unless bypassed, a new level must persist past the reject window before it is taken
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      lvl_r <= 1'b0;
      run_r <= 3'h0;
    end else if (s2_r != s3_r || s3_r == lvl_r) begin
      run_r <= 3'h0;
    end else if (bypass) begin
      lvl_r <= s3_r;
      run_r <= 3'h0;
    end else if (run_r == `MTC_FILT_ACCEPT_CYC - 3'h1) begin
      lvl_r <= s3_r;
      run_r <= 3'h0;
    end else begin
      run_r <= run_r + 3'h1;
    end
  end
endmodule : mtc_filter
`default_nettype wire

// File: verification/mtc_pulse_src.sv
// Behavioural external pulse source driving the timer input pin
`timescale 1ns/10ps
`default_nettype none
module mtc_pulse_src (
  input  wire logic mclk,
  output logic      pin
);
  initial pin = 1'b0;
  // Widths are whole clocks; only the filter check and the slow-mode bypass check ask for a width below twelve
  task automatic pulse(input int hi, input int lo);
    @(posedge mclk) pin <= 1'b1;
    repeat (hi) @(posedge mclk);
    pin <= 1'b0;
    repeat (lo) @(posedge mclk);
  endtask : pulse
endmodule : mtc_pulse_src
`default_nettype wire

// File: verification/tb_multimode_timer_counter.sv
// Self-checking testbench of the multimode timer counter
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
  $display("mismatch at %0t: got %h exp %h", $time, (a), (b)); end end
module tb_multimode_timer_counter;
  import mtc_pkg::*;
  logic        mclk;
  logic        nrst;
  logic        slow_tick;
  logic        stop_entry;
  logic        slow;
  mtc_avreq_t  req;
  logic [31:0] rd;
  logic        wr;
  logic        irq;
  wire logic   pin;
  int          err_count = 0;
  int          compares = 0;
  int          cyc = 0;
  int          irq_n = 0;
  int          t_last = 0;
  int          t_prev = 0;
  logic [31:0] dat;

  mtc_top DUT (.mclk(mclk), .nrst(nrst), .timer_input_pin(pin), .slow_mode(slow),
    .slow_clk_tick(slow_tick), .stop_entry(stop_entry), .avs_req(req),
    .avs_readdata(rd), .avs_waitrequest(wr), .match_interrupt(irq));
  mtc_pulse_src SRC (.mclk(mclk), .pin(pin));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    slow_tick <= (cyc[3:0] == 4'hf);
    if (irq === 1'b1) begin
      irq_n <= irq_n + 1;
      t_prev <= t_last;
      t_last <= cyc;
    end
  end

  function automatic logic [31:0] ctl(int ck, int md, int st, int ac, int ts);
    return {24'h0, ts[0], ac[0], st[1:0], md[1:0], ck[1:0]};
  endfunction : ctl

  function automatic int div(int c);
    return 2048 >> (4 * c);
  endfunction : div

  // Request held until waitrequest is seen low at a rising edge
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    req <= '{read: !w, write: w, address: a, writedata: d, byteenable: be};
    // No cap here: only the watchdog ends a stuck wait
    do begin
      @(posedge mclk);
      n++;
    end while (wr !== 1'b0);
    dat = rd;
    req <= '0;
    `CHK(n, 2)
    @(posedge mclk);
  endtask : av

  task automatic wait_irq();
    int n;
    int n0;
    n = 0;
    n0 = irq_n;
    while (irq_n == n0 && n < 20000) begin
      @(posedge mclk);
      n++;
    end
    `CHK(n < 20000, 1'b1)
    if (n >= 20000) end_of_test();
  endtask : wait_irq

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  // The tests need about 20k cycles; this allows 80k
  initial begin
    #2ms;
    err_count++;
    end_of_test();
  end

  initial begin
    logic [3:0]  ra [4];
    logic [15:0] rv [4];
    int          lim;
    int          n0;
    ra = '{4'h0, 4'h4, 4'h8, 4'h2};
    rv = '{16'h0000, 16'hffff, 16'h0000, 16'h0000};
    nrst = 1'b0;
    stop_entry = 1'b0;
    slow = 1'b0;
    slow_tick = 1'b0;
    req = '0;
    void'($urandom(54648));
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    for (int i = 0; i < 4; i++) begin
      av(1'b0, ra[i], 32'h0, 4'hf);
      `CHK(dat[15:0], rv[i])
    end
    $display("test reset values done");
    // Each divider tap code 00/01/10, limit random except where the period would be long
    for (int c = 0; c < 3; c++) begin
      lim = (c == 0) ? 2 : 2 + $urandom % 8;
      av(1'b1, 4'h0, 32'h0, 4'h3);
      av(1'b1, 4'h4, lim, 4'h3);
      av(1'b1, 4'h0, ctl(c, 0, 1, 0, 0), 4'h3);
      wait_irq();
      wait_irq();
      `CHK(irq, 1'b0)
      wait_irq();
      `CHK(t_last - t_prev, lim * div(c))
    end
    av(1'b1, 4'h0, ctl(2, 0, 1, 1, 0), 4'h3);
    repeat (20) @(posedge mclk);
    av(1'b0, 4'h8, 32'h0, 4'hf);
    `CHK(dat[15:0] < lim, 1'b1)
    av(1'b1, 4'h4, 32'h0030, 4'h1);
    repeat (20) @(posedge mclk);
    av(1'b0, 4'h4, 32'h0, 4'hf);
    `CHK(dat[15:0], 16'(lim))
    av(1'b1, 4'h4, 32'h000a, 4'h3);
    repeat (20) @(posedge mclk);
    av(1'b0, 4'h4, 32'h0, 4'hf);
    `CHK(dat[15:0], 16'h000a)
    $display("test free timer done");
    av(1'b1, 4'h0, ctl(2, 0, 2, 0, 0), 4'h3);
    n0 = irq_n;
    SRC.pulse(15, 15);
    SRC.pulse(15, 40);
    repeat (20) @(posedge mclk);
    `CHK(irq_n - n0, 1)
    repeat (40) @(posedge mclk);
    `CHK(irq_n - n0, 1)
    SRC.pulse(15, 120);
    `CHK(irq_n - n0, 2)
    av(1'b1, 4'h4, 32'h0064, 4'h3);
    av(1'b1, 4'h0, ctl(2, 0, 2, 0, 1), 4'h3);
    n0 = irq_n;
    SRC.pulse(40, 150);
    `CHK(irq_n - n0, 0)
    av(1'b0, 4'hc, 32'h0, 4'hf);
    `CHK(dat[16:0], 17'h0)
    $display("test trigger timer done");
    av(1'b1, 4'h4, 32'h0003, 4'h3);
    repeat (20) @(posedge mclk);
    av(1'b1, 4'h0, ctl(3, 0, 2, 0, 0), 4'h3);
    n0 = irq_n;
    SRC.pulse(4, 20);
    SRC.pulse(12, 12);
    SRC.pulse(12, 12);
    repeat (12) @(posedge mclk);
    av(1'b0, 4'hc, 32'h0, 4'hf);
    `CHK(dat[15:0], 16'h0002)
    SRC.pulse(12, 30);
    `CHK(irq_n - n0, 1)
    av(1'b0, 4'hc, 32'h0, 4'hf);
    `CHK(dat[15:0], 16'h0000)
    $display("test event counter done");
    av(1'b1, 4'h4, 32'hffff, 4'h3);
    av(1'b1, 4'h0, ctl(2, 1, 2, 0, 0), 4'h3);
    repeat (100) @(posedge mclk);
    av(1'b0, 4'hc, 32'h0, 4'hf);
    `CHK(dat[15:0], 16'h0000)
    SRC.pulse(80, 20);
    av(1'b0, 4'hc, 32'h0, 4'hf);
    `CHK(dat[15:0] >= 9 && dat[15:0] <= 11, 1'b1)
    av(1'b1, 4'h0, ctl(2, 1, 3, 0, 0), 4'h3);
    av(1'b0, 4'hc, 32'h0, 4'hf);
    n0 = dat[15:0];
    repeat (40) @(posedge mclk);
    av(1'b0, 4'hc, 32'h0, 4'hf);
    `CHK(dat[15:0] - n0 >= 5 && dat[15:0] - n0 <= 6, 1'b1)
    $display("test window done");
    av(1'b1, 4'h0, ctl(2, 0, 1, 0, 0), 4'h3);
    stop_entry <= 1'b1;
    @(posedge mclk);
    stop_entry <= 1'b0;
    @(posedge mclk);
    av(1'b0, 4'h0, 32'h0, 4'hf);
    `CHK(dat[5:4], 2'h0)
    av(1'b0, 4'hc, 32'h0, 4'hf);
    `CHK(dat[15:0], 16'h0000)
    $display("test stop entry done");
    // Slow mode: filter bypassed, only code 00 ticks, at fs/8
    slow <= 1'b1;
    av(1'b1, 4'h0, ctl(3, 0, 2, 0, 0), 4'h3);
    SRC.pulse(3, 10);
    av(1'b0, 4'hc, 32'h0, 4'hf);
    `CHK(dat[15:0], 16'h0001)
    av(1'b1, 4'h0, 32'h0, 4'h3);
    av(1'b1, 4'h4, 32'h0002, 4'h3);
    av(1'b1, 4'h0, ctl(1, 0, 1, 0, 0), 4'h3);
    repeat (300) @(posedge mclk);
    av(1'b0, 4'hc, 32'h0, 4'hf);
    `CHK(dat[15:0], 16'h0000)
    for (int s = 0; s < 2; s++) begin
      slow <= (s == 0);
      av(1'b1, 4'h0, ctl(0, 0, 1, 0, 0) | (s << 8), 4'h3);
      wait_irq();
      wait_irq();
      wait_irq();
      `CHK(t_last - t_prev, 2 * 16 * 8)
    end
    $display("test slow clock done");
    end_of_test();
  end
endmodule : tb_multimode_timer_counter
`default_nettype wire
